// ==== verilog/bit_matrix_pkg.sv ====
// constants for the bit matrix operation unit: register map, fields, codes
// assumes a 32-bit apb slave with byte addresses and one word per register
package bit_matrix_pkg;

  // array geometry: WORDS registers of 16 bits form one bit array
  localparam int unsigned   WORDS   = 4;
  localparam int unsigned   BITS    = 16 * WORDS;
  localparam int unsigned   WIDX_W  = 2;
  localparam logic [15:0]   LAST    = 16'h003f;

  // register byte offsets
  localparam logic [7:0]    CTRL_OFS   = 8'h00;
  localparam logic [7:0]    INDEX_OFS  = 8'h04;
  localparam logic [7:0]    STATUS_OFS = 8'h08;
  localparam logic [7:0]    COUNT_OFS  = 8'h0c;
  localparam logic [7:0]    A_BASE     = 8'h40;
  localparam logic [7:0]    B_BASE     = 8'h80;
  localparam logic [7:0]    ARR_SPAN   = 8'h10;

  // control register fields
  localparam int unsigned   C_OP_LSB   = 0;
  localparam int unsigned   C_EN       = 3;
  localparam int unsigned   C_PULSE    = 4;
  localparam int unsigned   C_SRC_B    = 5;
  localparam int unsigned   C_DST_B    = 6;
  localparam int unsigned   C_RESTART  = 7;
  localparam int unsigned   C_DIFFER   = 8;
  localparam int unsigned   C_ADVANCE  = 9;
  localparam int unsigned   C_PZERO    = 10;
  localparam int unsigned   C_BIT_IN   = 11;
  localparam int unsigned   C_ONES     = 12;
  localparam logic [31:0]   CTRL_MASK  = 32'h00001fff;
  localparam logic [31:0]   CTRL_RST   = 32'h00000000;

  // status register fields
  localparam int unsigned   S_HIT      = 0;
  localparam int unsigned   S_DONE     = 1;
  localparam int unsigned   S_FAULT    = 2;
  localparam int unsigned   S_ZERO     = 3;
  localparam int unsigned   S_BIT_OUT  = 4;

  // operation codes in the control op field
  localparam logic [2:0]    OP_IDLE    = 3'h0;
  localparam logic [2:0]    OP_COMPL   = 3'h1;
  localparam logic [2:0]    OP_SEARCH  = 3'h2;
  localparam logic [2:0]    OP_READ    = 3'h3;
  localparam logic [2:0]    OP_WRITE   = 3'h4;
  localparam logic [2:0]    OP_COUNT   = 3'h5;

endpackage

// ==== verilog/bit_matrix_operation_unit.sv ====
// bit matrix operation unit: two bit arrays, a bit index, five operations
// assumes an apb master on clk; ce low freezes every flip-flop
//
// How it works
// - array is WORDS 16-bit words, bit 16k+j is word k bit j
// - operation runs each cycle while enabled, or once per rising enable edge
// - complement writes the inverse of every source bit into the target
// - target may be the source array itself, overwritten in place
// - search starts at 0 on restart or last index, else just after index
// - search hunts differing pairs when differ is set, equal pairs otherwise
// - on a match the index takes its position and hit flag is set
// - reaching the last pair ends search, sets done, parks index at last
// - search with an out-of-range index sets fault and does nothing
// - bit read copies the indexed source bit onto bit out
// - pointer-zero request clears the index before a read
// - after read: done if index is last, else advance when asked
// - bit write applies pointer-zero first, then stores bit in
// - after write: done if index is last, else advance when asked
// - only the write that stores the last bit raises done
// - pointer-zero clears the index on its own, without enable, under the read and write codes only
// - read or write with out-of-range index sets fault, no access
// - count totals ones or zeros of the source into the count register
// - a zero count sets the zero-result flag
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module bit_matrix_operation_unit
  import bit_matrix_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             bit_out
);

  // register state
  logic [31:0]     ctrl;
  logic [15:0]     bit_index;
  logic [BITS-1:0] operand_a_array;
  logic [BITS-1:0] operand_b_array;
  logic            hit_flag;
  logic            scan_done;
  logic            pointer_fault;
  logic            zero_result;
  logic [15:0]     count_value;
  logic            enable_prev;

  logic [31:0]     next_ctrl;
  logic [15:0]     next_bit_index;
  logic [BITS-1:0] next_a;
  logic [BITS-1:0] next_b;
  logic            next_hit;
  logic            next_done;
  logic            next_fault;
  logic            next_zero;
  logic [15:0]     next_count;
  logic            next_bit_out;
  logic [31:0]     next_prdata;
  logic            next_pready;
  logic            next_pslverr;

  // decoded controls and datapath helpers
  logic [2:0]      op;
  logic            fire;
  logic            ptr_zero;
  logic [BITS-1:0] source_array;
  logic [BITS-1:0] match;
  logic [15:0]     start;
  logic [15:0]     pos;
  logic            found;
  logic [15:0]     eff;
  logic            bad_eff;
  logic            bad_idx;
  logic            src_bit;
  logic [15:0]     ones;
  logic [15:0]     cnt;
  logic            take;
  logic            wr;
  logic [WIDX_W-1:0] widx;
  logic            in_a;
  logic            in_b;

  assign op       = ctrl[C_OP_LSB +: 3];
  assign ptr_zero = ctrl[C_PZERO] && (op == OP_READ || op == OP_WRITE);
  // level mode runs every cycle, pulse mode only on the rising edge
  assign fire = ctrl[C_EN] && (!ctrl[C_PULSE] || !enable_prev) && op != OP_IDLE;
  assign source_array = ctrl[C_SRC_B] ? operand_b_array : operand_a_array;
  // pointer-zero takes effect ahead of the access
  assign eff     = ctrl[C_PZERO] ? 16'h0000 : bit_index;
  assign bad_eff = eff > LAST;
  assign bad_idx = bit_index > LAST;
  assign src_bit = source_array[eff[5:0]];

  // per-bit pair compare, differ or equal by the select bit
  genvar g;
  generate
    for (g = 0; g < BITS; g++) begin : g_pair
      assign match[g] = ctrl[C_DIFFER] ? (operand_a_array[g] ^ operand_b_array[g])
                                       : ~(operand_a_array[g] ^ operand_b_array[g]);
    end
  endgenerate

  // search start and first match at or after it; count of ones
  always_comb begin
    start = (ctrl[C_RESTART] || bit_index == LAST) ? 16'h0000
                                                   : bit_index + 16'h0001;
    found = 1'b0;
    pos   = LAST;
    ones  = 16'h0000;
    for (int i = BITS - 1; i >= 0; i--) begin
      if (i >= int'(start) && match[i]) begin
        found = 1'b1;
        pos   = 16'(i);
      end
    end
    // zeros are counted as the complement of ones, so one adder chain serves both
    for (int i = 0; i < BITS; i++) begin
      ones = ones + 16'(source_array[i]);
    end
    cnt = ctrl[C_ONES] ? ones : 16'(BITS) - ones;
  end

  // apb decode: array words sit in aligned windows above the control registers
  assign take = psel && penable && pready;
  assign wr   = take && pwrite;
  assign widx = paddr[WIDX_W+1:2];
  assign in_a = paddr >= A_BASE && paddr < A_BASE + ARR_SPAN && paddr[1:0] == 2'b00;
  assign in_b = paddr >= B_BASE && paddr < B_BASE + ARR_SPAN && paddr[1:0] == 2'b00;

  // bus answer: one wait state so that read data also comes from a flop
  always_comb begin
    next_pready  = psel && penable && !pready;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (psel && penable && !pready) begin
      if (in_a) begin
        next_prdata = {16'h0000, operand_a_array[16*widx +: 16]};
      end else if (in_b) begin
        next_prdata = {16'h0000, operand_b_array[16*widx +: 16]};
      end else begin
        case (paddr)
          CTRL_OFS:   next_prdata = ctrl;
          INDEX_OFS:  next_prdata = {16'h0000, bit_index};
          STATUS_OFS: next_prdata = {27'h0, bit_out, zero_result, pointer_fault,
                                     scan_done, hit_flag};
          COUNT_OFS:  next_prdata = {16'h0000, count_value};
          default:    next_pslverr = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // core: bus writes first, then the enabled operation overrides its targets
  always_comb begin
    next_ctrl      = ctrl;
    next_bit_index = bit_index;
    next_a         = operand_a_array;
    next_b         = operand_b_array;
    next_hit       = hit_flag;
    next_done      = scan_done;
    next_fault     = pointer_fault;
    next_zero      = zero_result;
    next_count     = count_value;
    next_bit_out   = bit_out;
    if (wr) begin
      if (in_a) begin
        next_a[16*widx +: 16] = pwdata[15:0];
      end else if (in_b) begin
        next_b[16*widx +: 16] = pwdata[15:0];
      end else if (paddr == CTRL_OFS) begin
        next_ctrl = pwdata & CTRL_MASK;
      end else if (paddr == INDEX_OFS) begin
        next_bit_index = pwdata[15:0];
      end
    end
    // pointer clear acts for read and write codes even with enable low
    if (ptr_zero) begin
      next_bit_index = 16'h0000;
    end
    // every branch settles its results in this one cycle
    if (fire) begin
      case (op)
        OP_COMPL: begin
          if (ctrl[C_DST_B]) begin
            next_b = ~source_array;
          end else begin
            next_a = ~source_array;
          end
        end
        OP_SEARCH: begin
          if (bad_idx) begin
            next_fault = 1'b1;
          end else begin
            next_fault     = 1'b0;
            next_hit       = found;
            next_bit_index = pos;
            next_done      = !found || pos == LAST;
          end
        end
        OP_READ: begin
          if (bad_eff) begin
            next_fault = 1'b1;
          end else begin
            next_fault   = 1'b0;
            next_bit_out = src_bit;
            next_done    = eff == LAST;
            if (eff != LAST && ctrl[C_ADVANCE]) begin
              next_bit_index = eff + 16'h0001;
            end
          end
        end
        OP_WRITE: begin
          if (bad_eff) begin
            next_fault = 1'b1;
          end else begin
            next_fault = 1'b0;
            if (ctrl[C_DST_B]) begin
              next_b[eff[5:0]] = ctrl[C_BIT_IN];
            end else begin
              next_a[eff[5:0]] = ctrl[C_BIT_IN];
            end
            // done only when the last bit is actually stored
            next_done = eff == LAST;
            if (eff != LAST && ctrl[C_ADVANCE]) begin
              next_bit_index = eff + 16'h0001;
            end
          end
        end
        OP_COUNT: begin
          next_count = cnt;
          next_zero  = cnt == 16'h0000;
        end
        default: begin
          next_fault = pointer_fault;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl            <= CTRL_RST;
      bit_index       <= 16'h0000;
      operand_a_array <= '0;
      operand_b_array <= '0;
      hit_flag        <= 1'b0;
      scan_done       <= 1'b0;
      pointer_fault   <= 1'b0;
      zero_result     <= 1'b0;
      count_value     <= 16'h0000;
      bit_out         <= 1'b0;
      enable_prev     <= 1'b0;
    end else if (ce) begin
      ctrl            <= next_ctrl;
      bit_index       <= next_bit_index;
      operand_a_array <= next_a;
      operand_b_array <= next_b;
      hit_flag        <= next_hit;
      scan_done       <= next_done;
      pointer_fault   <= next_fault;
      zero_result     <= next_zero;
      count_value     <= next_count;
      bit_out         <= next_bit_out;
      enable_prev     <= ctrl[C_EN];
    end
  end

  // checks; a bus write in the same cycle may also touch arrays or index
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence op_go(logic [2:0] code);
    ce && fire && op == code && !wr;
  endsequence

  // a write with its pointer in range; the shared first step of the in-range write checks
  sequence write_ok;
    op_go(OP_WRITE) and !bad_eff;
  endsequence

  // a read with its pointer in range
  sequence read_ok;
    op_go(OP_READ) and !bad_eff;
  endsequence

  // a search whose pointer is in range
  sequence search_ok;
    op_go(OP_SEARCH) and !bad_idx;
  endsequence

  complement_result_a: assert property (
    op_go(OP_COMPL) |=> (ctrl[C_DST_B] ? operand_b_array : operand_a_array)
                        == ~$past(source_array))
    else $error("complement result wrong");

  search_hit_a: assert property (
    search_ok and found |=> hit_flag && bit_index == $past(pos))
    else $error("search hit not recorded");

  search_end_a: assert property (
    search_ok and !found |=> scan_done && !hit_flag && bit_index == LAST)
    else $error("search end not recorded");

  search_skip_a: assert property (
    search_ok and (found && !ctrl[C_RESTART] && bit_index != LAST)
      |=> bit_index > $past(bit_index))
    else $error("search did not start after index");

  search_fault_a: assert property (
    op_go(OP_SEARCH) and bad_idx |=> pointer_fault && $stable(bit_index))
    else $error("search fault missing");

  read_value_a: assert property (
    read_ok |=> bit_out == $past(src_bit))
    else $error("read bit wrong");

  read_advance_a: assert property (
    read_ok and (eff != LAST && ctrl[C_ADVANCE])
      |=> !scan_done && bit_index == $past(eff) + 16'h0001)
    else $error("read did not advance the index");

  read_last_a: assert property (
    read_ok and eff == LAST |=> scan_done && bit_index == LAST)
    else $error("last read not flagged");

  read_fault_a: assert property (
    op_go(OP_READ) and bad_eff |=> pointer_fault && $stable(bit_out))
    else $error("read fault missing");

  write_store_a: assert property (
    write_ok |=> (ctrl[C_DST_B] ? operand_b_array[$past(eff[5:0])]
                                : operand_a_array[$past(eff[5:0])]) == ctrl[C_BIT_IN])
    else $error("written bit not stored");

  write_fault_a: assert property (
    op_go(OP_WRITE) and bad_eff
      |=> pointer_fault && $stable(operand_a_array) && $stable(operand_b_array))
    else $error("write fault missing");

  write_end_a: assert property (
    write_ok and (eff == LAST - 16'h0001 && ctrl[C_ADVANCE]) |=> !scan_done && bit_index == LAST)
    else $error("done raised before last write");

  write_last_a: assert property (
    write_ok and eff == LAST |=> scan_done && bit_index == $past(bit_index))
    else $error("last write not flagged");

  count_zero_a: assert property (
    op_go(OP_COUNT) |=> count_value == $past(cnt) && zero_result == (count_value == 16'h0000))
    else $error("count or zero flag wrong");

  pulse_once_a: assert property (
    ce && ctrl[C_EN] && ctrl[C_PULSE] && enable_prev |-> !fire)
    else $error("pulse mode fired twice");

  pointer_zero_a: assert property (
    ce && ptr_zero && !fire && !wr |=> bit_index == 16'h0000)
    else $error("pointer zero ignored");

endmodule // bit_matrix_operation_unit

// ==== verif/bit_matrix_operation_unit_tb.sv ====
// self-checking bench for the bit matrix operation unit, driven over apb
// assumes the slave answers within 50 cycles; expected reads queue up for the monitor
`timescale 1ns/1ps
module bit_matrix_operation_unit_tb;
  import bit_matrix_pkg::*;
  typedef struct packed {logic e; logic [31:0] m; logic [31:0] d;} note_t;
  localparam logic [31:0] EN   = (32'h1 << C_EN) | (32'h1 << C_PULSE);
  localparam logic [31:0] ADV  = 32'h1 << C_ADVANCE;
  localparam logic [31:0] DSTB = 32'h1 << C_DST_B;
  localparam logic [31:0] SRCB = 32'h1 << C_SRC_B;
  localparam logic [31:0] ONES = 32'h1 << C_ONES;
  localparam logic [31:0] PZ   = 32'h1 << C_PZERO;
  localparam logic [31:0] BIN  = 32'h1 << C_BIT_IN;
  logic        clk, reset, ce, psel, penable, pwrite, pready, pslverr, bit_out;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [63:0] a_m, b_m;
  note_t       q[$];
  note_t       n;
  int          n_errors, checks_done;

  bit_matrix_operation_unit i_bit_matrix_operation_unit (
    .clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_out(bit_out));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; a read leaves its expectation in the queue first
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    int k;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= w ? d : 32'h0;
    if (!w) q.push_back('{e, m, d});
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    psel <= 1'b0; penable <= 1'b0;
    if (k == 50) begin
      n_errors++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    apb(1'b0, a, d, m, 1'b0);
  endtask
  // pulse-mode launch, then enable back to 0 so the next launch is a fresh edge
  task automatic fire(input logic [2:0] op, input logic [31:0] f);
    wr(CTRL_OFS, 32'(op) | EN | f);
    wr(CTRL_OFS, 32'h0);
  endtask
  task automatic chk_arr(input logic [7:0] base, input logic [63:0] v);
    for (int k = 0; k < 4; k++) rd(base + 8'(4 * k), {16'h0, v[16 * k +: 16]}, '1);
  endtask
  task automatic cnt(input logic [31:0] f, input logic [63:0] v, input logic ones);
    int c;
    c = ones ? $countones(v) : 64 - $countones(v);
    fire(OP_COUNT, f);
    rd(COUNT_OFS, 32'(c), '1);
    rd(STATUS_OFS, (c == 0) ? 32'h8 : 32'h0, 32'h8);
  endtask
  // reference search: start point, pair match, end handling and range fault
  task automatic srch(input logic [15:0] ix, input logic rs, input logic df);
    int s;
    logic [15:0] ni;
    logic [31:0] st;
    wr(INDEX_OFS, {16'h0, ix});
    fire(OP_SEARCH, (32'(rs) << C_RESTART) | (32'(df) << C_DIFFER));
    if (ix > LAST) begin
      rd(INDEX_OFS, {16'h0, ix}, '1);
      rd(STATUS_OFS, 32'h4, 32'h4);
    end else begin
      s = (rs || ix == LAST) ? 0 : int'(ix) + 1;
      ni = LAST;
      st = 32'h2;
      for (int i = s; i < 64; i++) if ((a_m[i] ^ b_m[i]) == df) begin
        ni = 16'(i);
        st = (i == 63) ? 32'h3 : 32'h1;
        break;
      end
      rd(INDEX_OFS, {16'h0, ni}, '1);
      rd(STATUS_OFS, st, 32'h7);
    end
  endtask

  // monitor: every completed read takes the oldest note off the queue
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (q.size() == 0) check(33'h0, 33'h1);
      else begin
        n = q.pop_front();
        check({pslverr, prdata & n.m}, {n.e, n.d & n.m});
        if (paddr == STATUS_OFS && n.m[S_BIT_OUT])
          check({32'h0, bit_out}, {32'h0, n.d[S_BIT_OUT]});
      end
    end
  end

  initial begin
    reset = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; n_errors = 0; checks_done = 0;
    void'($urandom(23044));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // reset values and an unmapped place
    for (int k = 0; k < 4; k++) rd(8'(4 * k), 32'h0, '1);
    wr(8'h20, 32'hffffffff);
    apb(1'b0, 8'h20, 32'h0, '1, 1'b1);
    // random operands, upper halves must be dropped
    for (int k = 0; k < 4; k++) begin
      r = $urandom; wr(A_BASE + 8'(4 * k), r); a_m[16 * k +: 16] = r[15:0];
      r = $urandom; wr(B_BASE + 8'(4 * k), r); b_m[16 * k +: 16] = r[15:0];
    end
    chk_arr(A_BASE, a_m);
    chk_arr(B_BASE, b_m);
    for (int k = 0; k < 8; k++) srch(16'($urandom_range(62)), 1'($urandom), 1'($urandom));
    srch(16'h0046, 1'b0, 1'b1);
    srch(LAST, 1'b0, 1'b1);
    // bit read up to the last bit, then pointer-zero alone and with a read
    wr(INDEX_OFS, 32'd62);
    fire(OP_READ, ADV);
    rd(STATUS_OFS, {27'h0, a_m[62], 4'h0}, 32'h16);
    rd(INDEX_OFS, 32'd63, '1);
    fire(OP_READ, ADV);
    rd(STATUS_OFS, {27'h0, a_m[63], 4'h2}, 32'h16);
    rd(INDEX_OFS, 32'd63, '1);
    wr(CTRL_OFS, 32'(OP_READ) | PZ);
    wr(CTRL_OFS, 32'h0);
    rd(INDEX_OFS, 32'h0, '1);
    wr(INDEX_OFS, 32'd5);
    fire(OP_READ, PZ | ADV);
    rd(STATUS_OFS, {27'h0, a_m[0], 4'h0}, 32'h10);
    // bit write: moving onto the last bit leaves done low
    wr(INDEX_OFS, 32'd62);
    fire(OP_WRITE, DSTB | ADV | BIN);
    b_m[62] = 1'b1;
    rd(STATUS_OFS, 32'h0, 32'h6);
    rd(INDEX_OFS, 32'd63, '1);
    fire(OP_WRITE, DSTB | ADV);
    b_m[63] = 1'b0;
    rd(STATUS_OFS, 32'h2, 32'h6);
    chk_arr(B_BASE, b_m);
    // out of range pointer blocks read and write
    wr(INDEX_OFS, 32'd64);
    fire(OP_READ, ADV);
    rd(STATUS_OFS, 32'h4, 32'h4);
    fire(OP_WRITE, DSTB | BIN);
    rd(STATUS_OFS, 32'h4, 32'h4);
    rd(INDEX_OFS, 32'd64, '1);
    chk_arr(B_BASE, b_m);
    // complement into the other array, then in place exactly once
    fire(OP_COMPL, DSTB);
    b_m = ~a_m;
    chk_arr(B_BASE, b_m);
    srch(16'd10, 1'b0, 1'b0);
    fire(OP_COMPL, 32'h0);
    a_m = ~a_m;
    repeat (5) @(posedge clk);
    chk_arr(A_BASE, a_m);
    // level mode keeps executing: the read walks the index from 60 up to the end
    wr(INDEX_OFS, 32'd60);
    wr(CTRL_OFS, 32'(OP_READ) | (32'h1 << C_EN) | ADV);
    repeat (6) @(posedge clk);
    wr(CTRL_OFS, 32'h0);
    rd(INDEX_OFS, 32'd63, '1);
    rd(STATUS_OFS, {27'h0, a_m[63], 4'h2}, 32'h16);
    cnt(ONES, a_m, 1'b1);
    cnt(32'h0, a_m, 1'b0);
    for (int k = 0; k < 4; k++) wr(B_BASE + 8'(4 * k), 32'h0000ffff);
    b_m = '1;
    cnt(SRCB, b_m, 1'b0);
    cnt(SRCB | ONES, b_m, 1'b1);
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule // bit_matrix_operation_unit_tb
